// ---- peq_top.sv ----
/*
 * peq_top: pulse accumulators, edge timer and quadrature decoder behind
 * an APB slave, with a masked level interrupt.
 * Assumes terminal inputs already debounced and synchronous to core_clk,
 * and scan_tick a one-cycle pulse from the scan scheduler.
 */
// The APB slave port and the address map were chosen for this implementation.
// Behaviour
// - time one edge, result in microseconds
// - successive, previous-terminal and scan-spanning edge modes
// - timeout, or too-fast signal in single and successive modes, gives NaN marker
// - A leads counts up, B leads down
// - report direction and per-direction totals
// - x1 counts A rising up, A falling down
// - x2 counts both A edges
// - x4 counts all edges of A and B
// - 32-bit accumulator per pulse input
// - capture then clear accumulators at scan start
// - accumulators wrap, no saturation
// - frequency equals count over scan period
`timescale 1ns/10ps
module peq_top
    import peq_pkg::*;
(
    input  wire logic                      core_clk,  // 10 MHz clock
    input  wire logic                      reset,     // sync, active high
    input  wire logic                      psel,      // apb select
    input  wire logic                      penable,   // apb access phase
    input  wire logic                      pwrite,    // apb direction
    input  wire logic [peq_pkg::ADDR_W-1:0] paddr,    // apb byte address
    input  wire logic [peq_pkg::DATA_W-1:0] pwdata,   // apb write data
    output logic      [peq_pkg::DATA_W-1:0] prdata,   // apb read data
    output logic                           pready,    // apb ready
    output logic                           pslverr,   // apb error
    input  wire logic [peq_pkg::NUM_PULSE-1:0] pulse_in, // pulse terminals
    input  wire logic                      edge_in,   // timed terminal
    input  wire logic                      edge_prev_in, // preceding term.
    input  wire logic                      enc_a,     // encoder line a
    input  wire logic                      enc_b,     // encoder line b
    input  wire logic                      scan_tick, // scan start pulse
    output logic                           irq        // level interrupt
);
    import peq_pkg::*;

    logic [31:0]          ctrl_r, ctrl_nxt;
    logic [31:0]          tmo_r, tmo_nxt;
    logic [31:0]          scan_us_r, scan_us_nxt;
    logic [IRQ_W-1:0]     irq_en_r, irq_en_nxt;
    logic [IRQ_W-1:0]     irq_st_r, irq_st_nxt;
    logic [31:0]          prdata_r, prdata_nxt;
    logic [31:0]          acc_r [NUM_PULSE];
    logic [31:0]          acc_nxt [NUM_PULSE];
    logic [31:0]          cap_r [NUM_PULSE];
    logic [31:0]          cap_nxt [NUM_PULSE];
    logic [NUM_PULSE-1:0] pin_d_r;
    logic                 a_d_r, b_d_r, e_d_r, p_d_r;
    logic [31:0]          qnet_r, qnet_nxt, qfwd_r, qfwd_nxt;
    logic [31:0]          qrev_r, qrev_nxt;
    logic                 qdir_r, qdir_nxt;
    peq_est_t             est_r, est_nxt;
    logic [31:0]          eus_r, eus_nxt;
    logic [3:0]           esub_r, esub_nxt;
    logic [31:0]          eres_r, eres_nxt;
    logic                 ev_done, ev_nan;
    logic                 wr_en, rd_en;
    logic                 hit;

    peq_qmode_t qmode;
    peq_emode_t emode;
    assign qmode = peq_qmode_t'(ctrl_r[CTRL_QMODE_LO +: 2]);
    assign emode = peq_emode_t'(ctrl_r[CTRL_EMODE_LO +: 2]);

    // zero wait-state slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wr_en  = psel & penable & pwrite;
    // read data is loaded at the setup edge so it stands in the access phase
    assign rd_en  = psel & ~penable & ~pwrite;
    assign prdata = prdata_r;
    assign irq    = |(irq_st_r & irq_en_r);

    // address decode; unmapped offsets raise pslverr
    always_comb begin
        case (paddr)
            OFF_CTRL, OFF_TIMEOUT, OFF_PULSE0, OFF_PULSE1, OFF_EDGE_RES,
            OFF_QUAD_NET, OFF_QUAD_FWD, OFF_QUAD_REV, OFF_QUAD_DIR,
            OFF_IRQ_STAT, OFF_IRQ_EN, OFF_IRQ_CLR, OFF_SCAN_US: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit;

    // pulse accumulators: capture old value and restart in the same edge
    always_comb begin
        for (int i = 0; i < NUM_PULSE; i++) begin
            // rising edge counted even in the capture cycle
            if (scan_tick) begin
                cap_nxt[i] = acc_r[i];
                acc_nxt[i] = {31'h0, pulse_in[i] & ~pin_d_r[i]};
            end else begin
                cap_nxt[i] = cap_r[i];
                // plain 32-bit add wraps past 2^32 by design
                acc_nxt[i] = acc_r[i]
                           + {31'h0, pulse_in[i] & ~pin_d_r[i]};
            end
        end
    end

    // quadrature decode; direction taken from the level of the other line
    always_comb begin
        logic a_r_e, a_f_e, b_r_e, b_f_e, up, dn;
        a_r_e = enc_a & ~a_d_r;
        a_f_e = ~enc_a & a_d_r;
        b_r_e = enc_b & ~b_d_r;
        b_f_e = ~enc_b & b_d_r;
        up = 1'b0;
        dn = 1'b0;
        case (qmode)
            PEQ_Q_X1: begin
                up = a_r_e & ~enc_b;
                dn = a_f_e & ~enc_b;
            end
            PEQ_Q_X2: begin
                up = (a_r_e & ~enc_b) | (a_f_e & enc_b);
                dn = (a_r_e & enc_b) | (a_f_e & ~enc_b);
            end
            PEQ_Q_X4: begin
                up = (a_r_e & ~enc_b) | (a_f_e & enc_b)
                   | (b_r_e & enc_a) | (b_f_e & ~enc_a);
                dn = (a_r_e & enc_b) | (a_f_e & ~enc_b)
                   | (b_r_e & ~enc_a) | (b_f_e & enc_a);
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
        // net count follows a-leads-b as up
        qnet_nxt = qnet_r + (up ? 32'h1 : ZERO32) - (dn ? 32'h1 : ZERO32);
        qfwd_nxt = qfwd_r + (up ? 32'h1 : ZERO32);
        qrev_nxt = qrev_r + (dn ? 32'h1 : ZERO32);
        qdir_nxt = qdir_r;
        if (up | dn) begin
            qdir_nxt = dn;
        end
    end

    // edge timer: microsecond count between start and stop edges
    always_comb begin
        logic e_edge, p_edge, start_hit, stop_hit, tick_us;
        e_edge = ctrl_r[CTRL_POL_BIT] ? (~edge_in & e_d_r)
                                      : (edge_in & ~e_d_r);
        p_edge = ctrl_r[CTRL_POL_BIT] ? (~edge_prev_in & p_d_r)
                                      : (edge_prev_in & ~p_d_r);
        // start source per mode; stop source is always e_edge
        case (emode)
            PEQ_E_PREV_TERM: start_hit = p_edge;
            PEQ_E_SPAN:      start_hit = scan_tick;
            default:         start_hit = e_edge;
        endcase
        stop_hit = e_edge;
        tick_us  = (esub_r == CYC_US_M1);
        est_nxt  = est_r;
        eus_nxt  = eus_r;
        esub_nxt = tick_us ? 4'h0 : esub_r + 4'h1;
        eres_nxt = eres_r;
        ev_done  = 1'b0;
        ev_nan   = 1'b0;
        case (est_r)
            PEQ_ST_IDLE: begin
                if (wr_en && paddr == OFF_CTRL && pwdata[CTRL_ARM_BIT]) begin
                    est_nxt = PEQ_ST_WAIT_START;
                    eus_nxt = ZERO32;
                end
            end
            PEQ_ST_WAIT_START: begin
                if (start_hit) begin
                    est_nxt  = PEQ_ST_WAIT_STOP;
                    eus_nxt  = ZERO32;
                    esub_nxt = 4'h0;
                end else if (tick_us) begin
                    eus_nxt = eus_r + 32'h1;
                end
                if (!start_hit && tick_us && eus_r >= tmo_r) begin
                    est_nxt  = PEQ_ST_IDLE;
                    eres_nxt = NAN_MARK;
                    ev_nan   = 1'b1;
                end
            end
            PEQ_ST_WAIT_STOP: begin
                if (stop_hit && emode != PEQ_E_PREV_TERM
                        && emode != PEQ_E_SPAN && eus_r == ZERO32) begin
                    // stop within the first microsecond: too fast
                    est_nxt  = PEQ_ST_IDLE;
                    eres_nxt = NAN_MARK;
                    ev_nan   = 1'b1;
                end else if (stop_hit) begin
                    est_nxt  = PEQ_ST_IDLE;
                    eres_nxt = eus_r;
                    ev_done  = 1'b1;
                end else if (tick_us) begin
                    eus_nxt = eus_r + 32'h1;
                    if (eus_r >= tmo_r) begin
                        est_nxt  = PEQ_ST_IDLE;
                        eres_nxt = NAN_MARK;
                        ev_nan   = 1'b1;
                    end
                end
            end
            default: est_nxt = PEQ_ST_IDLE;
        endcase
    end

    // register writes, sticky status with set winning over clear
    always_comb begin
        ctrl_nxt    = ctrl_r;
        tmo_nxt     = tmo_r;
        scan_us_nxt = scan_us_r;
        irq_en_nxt  = irq_en_r;
        irq_st_nxt  = irq_st_r;
        if (wr_en) begin
            case (paddr)
                // arm bit is a strobe, never stored
                OFF_CTRL:    ctrl_nxt = pwdata & ~(32'h1 << CTRL_ARM_BIT);
                OFF_TIMEOUT: tmo_nxt = pwdata;
                OFF_SCAN_US: scan_us_nxt = pwdata;
                OFF_IRQ_EN:  irq_en_nxt = pwdata[IRQ_W-1:0];
                OFF_IRQ_CLR: irq_st_nxt = irq_st_r & ~pwdata[IRQ_W-1:0];
                default:     ctrl_nxt = ctrl_r;
            endcase
        end
        irq_st_nxt[IRQ_SCAN]      = irq_st_nxt[IRQ_SCAN] | scan_tick;
        irq_st_nxt[IRQ_EDGE_DONE] = irq_st_nxt[IRQ_EDGE_DONE] | ev_done;
        irq_st_nxt[IRQ_EDGE_NAN]  = irq_st_nxt[IRQ_EDGE_NAN] | ev_nan;
    end

    // read mux; frequency is left to software as capture over scan
    // period, so resolution is one pulse per scan
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_en) begin
            case (paddr)
                OFF_CTRL:     prdata_nxt = ctrl_r;
                OFF_TIMEOUT:  prdata_nxt = tmo_r;
                OFF_PULSE0:   prdata_nxt = cap_r[0];
                OFF_PULSE1:   prdata_nxt = cap_r[1];
                OFF_EDGE_RES: prdata_nxt = eres_r;
                OFF_QUAD_NET: prdata_nxt = qnet_r;
                OFF_QUAD_FWD: prdata_nxt = qfwd_r;
                OFF_QUAD_REV: prdata_nxt = qrev_r;
                OFF_QUAD_DIR: prdata_nxt = {31'h0, qdir_r};
                OFF_IRQ_STAT: prdata_nxt = {29'h0, irq_st_r};
                OFF_SCAN_US:  prdata_nxt = scan_us_r;
                default:      prdata_nxt = ZERO32;
            endcase
        end
    end

    // prdata_r is loaded at the setup edge and holds until the next read
    // setup, so the master takes it at the edge where pready is high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r    <= ZERO32;
            tmo_r     <= TIMEOUT_RST;
            scan_us_r <= ZERO32;
            irq_en_r  <= '0;
            irq_st_r  <= '0;
            prdata_r  <= ZERO32;
            pin_d_r   <= '0;
            a_d_r     <= 1'b0;
            b_d_r     <= 1'b0;
            e_d_r     <= 1'b0;
            p_d_r     <= 1'b0;
            qnet_r    <= ZERO32;
            qfwd_r    <= ZERO32;
            qrev_r    <= ZERO32;
            qdir_r    <= 1'b0;
            est_r     <= PEQ_ST_IDLE;
            eus_r     <= ZERO32;
            esub_r    <= 4'h0;
            eres_r    <= ZERO32;
            for (int i = 0; i < NUM_PULSE; i++) begin
                acc_r[i] <= ZERO32;
                cap_r[i] <= ZERO32;
            end
        end else begin
            ctrl_r    <= ctrl_nxt;
            tmo_r     <= tmo_nxt;
            scan_us_r <= scan_us_nxt;
            irq_en_r  <= irq_en_nxt;
            irq_st_r  <= irq_st_nxt;
            prdata_r  <= prdata_nxt;
            pin_d_r   <= pulse_in;
            a_d_r     <= enc_a;
            b_d_r     <= enc_b;
            e_d_r     <= edge_in;
            p_d_r     <= edge_prev_in;
            qnet_r    <= qnet_nxt;
            qfwd_r    <= qfwd_nxt;
            qrev_r    <= qrev_nxt;
            qdir_r    <= qdir_nxt;
            est_r     <= est_nxt;
            eus_r     <= eus_nxt;
            esub_r    <= esub_nxt;
            eres_r    <= eres_nxt;
            for (int i = 0; i < NUM_PULSE; i++) begin
                acc_r[i] <= acc_nxt[i];
                cap_r[i] <= cap_nxt[i];
            end
        end
    end
endmodule

// ---- peq_pkg.sv ----
/*
 * peq_pkg: shared constants for the pulse, edge-timing and quadrature
 * counter block.
 * Assumes a 10 MHz core clock and 32-bit APB register access.
 */
package peq_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          NUM_PULSE     = 2;
    // clock figures, time base for edge timing in microseconds
    localparam int          CLK_HZ        = 10000000;
    localparam int          US_PER_S      = 1000000;
    localparam int          CYC_PER_US    = CLK_HZ / US_PER_S;
    localparam logic [3:0]  CYC_US_M1     = 4'(CYC_PER_US - 1);
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_TIMEOUT   = 8'h04;
    localparam logic [7:0]  OFF_PULSE0    = 8'h08;
    localparam logic [7:0]  OFF_PULSE1    = 8'h0c;
    localparam logic [7:0]  OFF_EDGE_RES  = 8'h10;
    localparam logic [7:0]  OFF_QUAD_NET  = 8'h14;
    localparam logic [7:0]  OFF_QUAD_FWD  = 8'h18;
    localparam logic [7:0]  OFF_QUAD_REV  = 8'h1c;
    localparam logic [7:0]  OFF_QUAD_DIR  = 8'h20;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h24;
    localparam logic [7:0]  OFF_IRQ_EN    = 8'h28;
    localparam logic [7:0]  OFF_IRQ_CLR   = 8'h2c;
    localparam logic [7:0]  OFF_SCAN_US   = 8'h30;
    // control field layout
    localparam int          CTRL_QMODE_LO = 0;
    localparam int          CTRL_EMODE_LO = 2;
    localparam int          CTRL_ARM_BIT  = 4;
    localparam int          CTRL_POL_BIT  = 5;
    // irq bits
    localparam int          IRQ_SCAN      = 0;
    localparam int          IRQ_EDGE_DONE = 1;
    localparam int          IRQ_EDGE_NAN  = 2;
    localparam int          IRQ_W         = 3;
    // reset values, nan result marker and zero
    localparam logic [31:0] TIMEOUT_RST   = 32'h000f4240;
    localparam logic [31:0] NAN_MARK      = 32'h7fc00000;
    localparam logic [31:0] ZERO32        = 32'h00000000;

    // quadrature resolution modes
    typedef enum logic [1:0] {
        PEQ_Q_X1,
        PEQ_Q_X2,
        PEQ_Q_X4,
        PEQ_Q_OFF
    } peq_qmode_t;

    // edge timing modes
    typedef enum logic [1:0] {
        PEQ_E_SINGLE,
        PEQ_E_SUCCESSIVE,
        PEQ_E_PREV_TERM,
        PEQ_E_SPAN
    } peq_emode_t;

    typedef enum logic [1:0] {
        PEQ_ST_IDLE,
        PEQ_ST_WAIT_START,
        PEQ_ST_WAIT_STOP
    } peq_est_t;
endpackage

// ---- peq_assertions.sv ----
/* peq_assertions: port checks for peq_top, bound below.
   Assumes one core_clk domain and read data standing in the access
   phase, loaded at the setup edge. */
`timescale 1ns/10ps
module peq_assertions
    import peq_pkg::*;
(
    input wire logic                          core_clk,     // clock
    input wire logic                          reset,        // sync reset
    input wire logic                          psel,         // select
    input wire logic                          penable,      // access
    input wire logic                          pwrite,       // direction
    input wire logic [peq_pkg::ADDR_W-1:0]    paddr,        // address
    input wire logic [peq_pkg::DATA_W-1:0]    pwdata,       // write data
    input wire logic [peq_pkg::DATA_W-1:0]    prdata,       // read data
    input wire logic                          pready,       // ready
    input wire logic                          pslverr,      // error
    input wire logic [peq_pkg::NUM_PULSE-1:0] pulse_in,     // pulses
    input wire logic                          edge_in,      // timed
    input wire logic                          edge_prev_in, // preceding
    input wire logic                          enc_a,        // line a
    input wire logic                          enc_b,        // line b
    input wire logic                          scan_tick,    // scan start
    input wire logic                          irq           // interrupt
);
    logic [1:0]       prv_r, rise;
    logic [1:0][31:0] acc_r, acc_nxt, cap_r, cap_nxt;
    logic             rd_any, rd_setup, unmap;

    // decoded bus and edge events
    assign rise = pulse_in & ~prv_r;
    assign rd_any = psel && penable && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign unmap = paddr > OFF_SCAN_US;
    // shadow accumulators; a scan-cycle edge opens the new interval
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            acc_nxt[i] = scan_tick ? 32'(rise[i]) : acc_r[i] + 32'(rise[i]);
            cap_nxt[i] = scan_tick ? acc_r[i] : cap_r[i];
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prv_r <= '0;
            acc_r <= '0;
            cap_r <= '0;
        end else begin
            prv_r <= pulse_in;
            acc_r <= acc_nxt;
            cap_r <= cap_nxt;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // a read that does not collide with a capture
    sequence s_rd(logic [7:0] a);
        rd_any && paddr == a && !scan_tick;
    endsequence

    a_pulse0_capture: assert property (s_rd(OFF_PULSE0) |->
        prdata == $past(cap_r[0])) else $error("pulse0 capture wrong");
    a_pulse1_capture: assert property (s_rd(OFF_PULSE1) |->
        prdata == $past(cap_r[1])) else $error("pulse1 capture wrong");
    a_unmap_error: assert property (psel && penable && unmap |-> pslverr)
        else $error("no error on unmapped access");
    a_unmap_zero: assert property (rd_any && unmap |-> prdata == ZERO32)
        else $error("unmapped read not zero");
    a_map_clean: assert property (psel && penable && !unmap &&
        paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
    a_rdata_hold: assert property (!rd_setup |=> $stable(prdata))
        else $error("read data moved without a read");
    a_ready_high: assert property (pready) else $error("pready low");
    a_irq_quiet: assert property ($fell(reset) |-> !irq)
        else $error("irq high after reset");
endmodule
bind peq_top peq_assertions u_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
    .edge_in(edge_in), .edge_prev_in(edge_prev_in), .enc_a(enc_a),
    .enc_b(enc_b), .scan_tick(scan_tick), .irq(irq)
);

// ---- peq_enc_model.sv ----
/* peq_enc_model: behavioural shaft encoder on the quadrature lines.
   Assumes step requests are one-cycle pulses on core_clk. */
`timescale 1ns/10ps
module peq_enc_model (
    input  wire logic core_clk, // clock
    input  wire logic reset,    // sync reset
    input  wire logic step,     // one quarter step
    input  wire logic fwd,      // 1 = line a leads
    output logic      enc_a,    // line a
    output logic      enc_b     // line b
);
    logic [1:0] ph_r, ph_nxt;

    // phase counts 00,01,10,11 forward and lines a,b walk 00,10,11,01, so only one line moves per step
    always_comb begin
        ph_nxt = ph_r;
        if (step) begin
            ph_nxt = fwd ? ph_r + 2'h1 : ph_r - 2'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        ph_r <= reset ? 2'h0 : ph_nxt;
    end
    assign enc_a = ph_r[1] ^ ph_r[0];
    assign enc_b = ph_r[1];
endmodule

// ---- testbench.sv ----
/* testbench: apb register tests of peq_top with pulse, edge and encoder
   stimulus. Assumes peq_enc_model and the bound checker are compiled. */
`timescale 1ns/10ps
module testbench;
    import peq_pkg::*;
    logic        core_clk = 1'b0, reset = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, enc_a, enc_b;
    logic [1:0]  pulse_in = 2'h0;
    logic        edge_in = 1'b0, edge_prev_in = 1'b0, scan_tick = 1'b0;
    logic        step = 1'b0, fwd = 1'b0;
    int          err_total = 0, cmp_count = 0, net = 0, fw = 0, rv = 0, k;

    always #50 core_clk = ~core_clk;
    peq_top u_dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
        .edge_in(edge_in), .edge_prev_in(edge_prev_in), .enc_a(enc_a),
        .enc_b(enc_b), .scan_tick(scan_tick), .irq(irq)
    );
    // encoder pair used for quadrature only, never shared
    peq_enc_model u_enc (
        .core_clk(core_clk), .reset(reset), .step(step), .fwd(fwd),
        .enc_a(enc_a), .enc_b(enc_b)
    );

    task automatic summarize();
        $display("mismatches %0d of %0d checks", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // setup then access; read data is taken at the edge with pready high
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        tick(1);
        penable <= 1'b1;
        tick(1);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            tick(1);
        end
        if (n == 50) begin
            err_total++;
            summarize();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        tick(1);
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic pulses(logic [1:0] m, int n);
        repeat (n) begin
            pulse_in <= m;
            tick(2);
            pulse_in <= 2'h0;
            tick(2);
        end
    endtask
    task automatic scan();
        scan_tick <= 1'b1;
        tick(1);
        scan_tick <= 1'b0;
        tick(1);
    endtask
    task automatic steps(logic f, int n);
        repeat (n) begin
            fwd <= f;
            step <= 1'b1;
            tick(1);
            step <= 1'b0;
            tick(4);
        end
    endtask
    // arm, fire the start source, stop on edge_in gap cycles later
    task automatic tm(logic [31:0] c, int s, int gap);
        bus(1'b1, OFF_CTRL, c);
        {scan_tick, edge_prev_in, edge_in} <= 3'(1 << s);
        tick(1);
        {scan_tick, edge_prev_in, edge_in} <= 3'h0;
        tick(gap - 1);
        edge_in <= 1'b1;
        tick(1);
        edge_in <= 1'b0;
        tick(5);
        bus(1'b0, OFF_EDGE_RES, 32'h0);
    endtask

    initial begin
        tick(6);
        reset <= 1'b0;
        tick(1);
        rdc(OFF_TIMEOUT, TIMEOUT_RST);
        // counts, capture with clear, scan interrupt raise and mask
        pulses(2'h3, 3);
        pulses(2'h2, 2);
        bus(1'b1, OFF_IRQ_EN, 32'h1);
        scan();
        chk(32'(irq), 32'h1);
        rdc(OFF_PULSE0, 32'h3);
        rdc(OFF_PULSE1, 32'h5);
        bus(1'b1, OFF_IRQ_CLR, 32'h1);
        chk(32'(irq), 32'h0);
        bus(1'b1, OFF_IRQ_EN, 32'h0);
        pulse_in <= 2'h1;
        scan();
        pulse_in <= 2'h0;
        rdc(OFF_PULSE0, ZERO32);
        scan();
        rdc(OFF_PULSE0, 32'h1);
        chk(32'(irq), 32'h0);
        // each resolution: two turns forward, one back
        for (int m = 0; m < 4; m++) begin
            k = (m == 3) ? 0 : 1 << m;
            bus(1'b1, OFF_CTRL, 32'(m));
            steps(1'b1, 8);
            steps(1'b0, 4);
            net += k;
            fw += 2 * k;
            rv += k;
            rdc(OFF_QUAD_NET, 32'(net));
            rdc(OFF_QUAD_FWD, 32'(fw));
            rdc(OFF_QUAD_REV, 32'(rv));
            rdc(OFF_QUAD_DIR, 32'h1);
        end
        // one forward quarter step in x4 flips the direction back
        bus(1'b1, OFF_CTRL, 32'h2);
        steps(1'b1, 1);
        rdc(OFF_QUAD_NET, 32'(net + 1));
        rdc(OFF_QUAD_DIR, 32'h0);
        // edge timer with the decoder switched off
        tm(32'h13, 0, 50);
        chk(32'(rd >= 32'h4 && rd <= 32'h5), 32'h1);
        tm(32'h1b, 1, 30);
        chk(32'(rd >= 32'h2 && rd <= 32'h3), 32'h1);
        tm(32'h1f, 2, 20);
        chk(32'(rd >= 32'h1 && rd <= 32'h2), 32'h1);
        // successive mode on falling edges
        tm(32'h37, 0, 30);
        chk(32'(rd >= 32'h2 && rd <= 32'h3), 32'h1);
        tm(32'h13, 0, 4);
        chk(rd, NAN_MARK);
        bus(1'b1, OFF_TIMEOUT, 32'h3);
        bus(1'b1, OFF_CTRL, 32'h13);
        tick(60);
        rdc(OFF_EDGE_RES, NAN_MARK);
        rdc(OFF_IRQ_STAT, 32'h7);
        bus(1'b1, OFF_SCAN_US, 32'h000f4240);
        rdc(OFF_SCAN_US, 32'h000f4240);
        rdc(8'h34, ZERO32);
        summarize();
    end
endmodule
